// ---- design/breaker_flashover_detector.sv ----
// breaker flashover detector evaluated once per protection pass
module breaker_flashover_detector #(
  parameter int MAG_W = flashover_pkg::MAG_W_DEF,
  parameter int DLY_W = flashover_pkg::DLY_W_DEF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // protection pass strobe from the sequencer
  input wire logic pass_stb,
  // settings
  input wire logic second_side_source_select,
  input wire logic contact_in_use,
  input wire logic delta_connected,
  input wire logic [MAG_W-1:0] phase_voltage_pickup,
  input wire logic [MAG_W-1:0] voltage_difference_pickup,
  input wire logic [MAG_W-1:0] current_pickup,
  input wire logic [DLY_W-1:0] operate_delay,
  // per-phase measurements from source_one and source_two
  input wire logic [flashover_pkg::PHASES-1:0][MAG_W-1:0] side1_voltage,
  input wire logic [flashover_pkg::PHASES-1:0][MAG_W-1:0] side2_voltage,
  input wire logic [flashover_pkg::PHASES-1:0][MAG_W-1:0] voltage_difference,
  input wire logic [flashover_pkg::PHASES-1:0][MAG_W-1:0] phase_current,
  // breaker pole contacts (pins) and supervision operands
  input wire logic [flashover_pkg::PHASES-1:0] breaker_closed_aux_contact,
  input wire logic [flashover_pkg::PHASES-1:0] supervision_operand,
  // indications
  output logic [flashover_pkg::PHASES-1:0] phase_pickup,
  output logic [flashover_pkg::PHASES-1:0] phase_operate,
  output logic pickup_any,
  output logic operate_any
);
  import flashover_pkg::*;

  // refuse widths that the comparators and the delay timer cannot serve
  if (MAG_W < 2 || DLY_W < 1) begin : g_bad_width
    $error("breaker_flashover_detector: width parameter too small");
  end

  function automatic logic above(input logic [MAG_W-1:0] a, input logic [MAG_W-1:0] b);
    above = a > b;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // two-flop synchroniser on the pole contacts; only stage 2 is read
  logic [PHASES-1:0] aux_s1_r;
  logic [PHASES-1:0] aux_s2_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aux_s1_r <= '0;
      aux_s2_r <= '0;
    end else begin
      aux_s1_r <= breaker_closed_aux_contact;
      aux_s2_r <= aux_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // supervision hold, one per pole
  logic [PHASES-1:0] blk;
  spv_if spv [PHASES] ();
  for (genvar g = 0; g < PHASES; g++) begin : g_spv
    assign spv[g].pass_stb = pass_stb;
    assign spv[g].spv_raw = supervision_operand[g];
    assign blk[g] = spv[g].spv_block;
    spv_hold u_hold (
      .core_clk(core_clk),
      .rstn(rstn),
      .sp(spv[g])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // per-phase conditions
  logic [PHASES-1:0] cur_on;
  logic [PHASES-1:0] brk_open;
  logic [PHASES-1:0] pre_ok;
  logic [PHASES-1:0] flash_ok;
  logic no_current;
  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      cur_on[i] = above(phase_current[i], current_pickup);
      brk_open[i] = !aux_s2_r[i];
    end
    no_current = !(|cur_on);
    for (int i = 0; i < PHASES; i++) begin
      if (!second_side_source_select) begin
        // difference deliberately unused here
        pre_ok[i] = above(side1_voltage[i], phase_voltage_pickup)
                    && brk_open[i] && no_current;
        flash_ok[i] = brk_open[i] && !above(side1_voltage[i], phase_voltage_pickup)
                      && cur_on[i];
      end else begin
        // one dead side still gives a large difference
        pre_ok[i] = above(voltage_difference[i], voltage_difference_pickup)
                    && (above(side1_voltage[i], phase_voltage_pickup)
                        || above(side2_voltage[i], phase_voltage_pickup))
                    && no_current && (brk_open[i] || !contact_in_use);
        flash_ok[i] = !above(side1_voltage[i], phase_voltage_pickup)
                      && !above(side2_voltage[i], phase_voltage_pickup)
                      && !above(voltage_difference[i], voltage_difference_pickup)
                      && cur_on[i] && (brk_open[i] || !contact_in_use);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-phase sequence: idle, armed, pickup with timer, operate
  fo_state_t state_r [PHASES];
  fo_state_t state_nxt [PHASES];
  logic [DLY_W-1:0] timer_r [PHASES];
  logic [DLY_W-1:0] timer_nxt [PHASES];
  logic [PHASES-1:0] pick_nxt;
  logic [PHASES-1:0] oper_nxt;
  logic [PHASES-1:0] reset_cond;
  logic pick_any_nxt;
  logic oper_any_nxt;
  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      state_nxt[i] = state_r[i];
      timer_nxt[i] = timer_r[i];
      reset_cond[i] = !cur_on[i] || aux_s2_r[i] || blk[i];
      if (delta_connected) begin
        state_nxt[i] = ST_IDLE;
        timer_nxt[i] = '0;
      end else if (pass_stb) begin
        case (state_r[i])
          ST_IDLE: begin
            // arming first means voltage was present beforehand
            if (pre_ok[i] && !blk[i]) begin
              state_nxt[i] = ST_ARMED;
            end
          end
          ST_ARMED: begin
            timer_nxt[i] = '0;
            if (blk[i] || aux_s2_r[i]) begin
              state_nxt[i] = ST_IDLE;
            end else if (flash_ok[i]) begin
              state_nxt[i] = ST_PICKUP;
            end else if (!pre_ok[i]) begin
              state_nxt[i] = ST_IDLE;
            end
          end
          ST_PICKUP: begin
            if (reset_cond[i]) begin
              state_nxt[i] = ST_IDLE;
              timer_nxt[i] = '0;
            end else if (!flash_ok[i]) begin
              state_nxt[i] = ST_ARMED;
              timer_nxt[i] = '0;
            end else if (timer_r[i] >= operate_delay) begin
              state_nxt[i] = ST_OPERATE;
            end else begin
              timer_nxt[i] = timer_r[i] + DLY_W'(1);
            end
          end
          ST_OPERATE: begin
            // operate seals in until one of the reset causes appears
            if (reset_cond[i]) begin
              state_nxt[i] = ST_IDLE;
              timer_nxt[i] = '0;
            end
          end
          default: begin
            state_nxt[i] = ST_IDLE;
            timer_nxt[i] = '0;
          end
        endcase
      end
      pick_nxt[i] = (state_nxt[i] == ST_PICKUP) || (state_nxt[i] == ST_OPERATE);
      oper_nxt[i] = state_nxt[i] == ST_OPERATE;
    end
    pick_any_nxt = |pick_nxt;
    oper_any_nxt = |oper_nxt;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < PHASES; i++) begin
        state_r[i] <= ST_IDLE;
        timer_r[i] <= '0;
      end
      phase_pickup <= '0;
      phase_operate <= '0;
      pickup_any <= 1'b0;
      operate_any <= 1'b0;
    end else begin
      for (int i = 0; i < PHASES; i++) begin
        state_r[i] <= state_nxt[i];
        timer_r[i] <= timer_nxt[i];
      end
      phase_pickup <= pick_nxt;
      phase_operate <= oper_nxt;
      pickup_any <= pick_any_nxt;
      operate_any <= oper_any_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks on phase A, plus element-level relations
  delta_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
    delta_connected |=> !pickup_any && !operate_any)
    else $error("pickup while delta voltages applied");
  prior_volt_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(phase_pickup[0]) |-> $past(state_r[0] == ST_ARMED))
    else $error("pickup without prior armed voltage");
  three_arm_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r[0] == ST_IDLE && pass_stb && !second_side_source_select && !delta_connected
    && !blk[0] && above(side1_voltage[0], phase_voltage_pickup) && !aux_s2_r[0]
    && no_current |=> state_r[0] == ST_ARMED)
    else $error("three-transformer arming missed");
  three_flash_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r[0] == ST_ARMED && pass_stb && !second_side_source_select && !delta_connected
    && !blk[0] && !aux_s2_r[0] && cur_on[0]
    && !above(side1_voltage[0], phase_voltage_pickup) |=> phase_pickup[0])
    else $error("three-transformer flashover missed");
  six_flash_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r[0] == ST_ARMED && pass_stb && second_side_source_select && !delta_connected
    && !blk[0] && !aux_s2_r[0] && flash_ok[0] |=> phase_pickup[0] && timer_r[0] == '0)
    else $error("six-transformer flashover missed");
  delay_met_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(phase_operate[0]) |-> $past(timer_r[0]) >= $past(operate_delay))
    else $error("operate before delay");
  reset_cur_a: assert property (@(posedge core_clk) disable iff (!rstn)
    phase_pickup[0] && pass_stb && !cur_on[0] |=> !phase_pickup[0] ##1 !phase_operate[0])
    else $error("pickup held with no current");
  restart_a: assert property (@(posedge core_clk) disable iff (!rstn)
    state_r[0] == ST_PICKUP && pass_stb && !reset_cond[0] && !flash_ok[0] && !delta_connected
    |=> !phase_pickup[0] && timer_r[0] == '0)
    else $error("timer not restarted");
  or_pickup_a: assert property (@(posedge core_clk) disable iff (!rstn)
    pickup_any == |phase_pickup && operate_any == |phase_operate)
    else $error("element pickup not OR of phases");
  super_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
    blk[0] && pass_stb |=> !phase_pickup[0])
    else $error("pickup while supervised");

  pickup_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) $rose(pickup_any));
  operate_seen_c: cover property (@(posedge core_clk) disable iff (!rstn) $rose(operate_any));
  six_mode_c: cover property (@(posedge core_clk) disable iff (!rstn)
    second_side_source_select && $rose(phase_pickup[1]));
endmodule

// ---- design/flashover_pkg.sv ----
// shared constants and types for the breaker flashover detector
package flashover_pkg;
  localparam int PHASES = 3;
  // protection passes run eight times per power system cycle
  localparam int PASSES_PER_CYCLE = 8;
  // supervision blocking lingers this many power cycles after release
  localparam int SPV_HOLD_CYCLES = 6;
  localparam int SPV_HOLD_PASSES = SPV_HOLD_CYCLES * PASSES_PER_CYCLE;
  localparam int SPV_CNT_W = $clog2(SPV_HOLD_PASSES + 1);
  localparam logic [SPV_CNT_W-1:0] SPV_HOLD_LOAD = SPV_CNT_W'(SPV_HOLD_PASSES);
  localparam logic [SPV_CNT_W-1:0] SPV_CNT_RST = '0;
  // default measurement and timer widths
  localparam int MAG_W_DEF = 16;
  localparam int DLY_W_DEF = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PICKUP, ST_OPERATE} fo_state_t;
endpackage

// ---- design/spv_if.sv ----
// carrier between the detector and its per-pole supervision hold
interface spv_if;
  logic pass_stb;
  logic spv_raw;
  logic spv_block;
  modport elem (output pass_stb, output spv_raw, input spv_block);
  modport hold (input pass_stb, input spv_raw, output spv_block);
endinterface

// ---- design/spv_hold.sv ----
// per-pole supervision gate with a six power-cycle release hold
module spv_hold (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // supervision link
  spv_if.hold sp
);
  import flashover_pkg::*;

  logic [SPV_CNT_W-1:0] cnt_r;
  logic [SPV_CNT_W-1:0] cnt_nxt;
  logic block_r;
  logic block_nxt;

  ////////////////////////////////////////////////////////////////////
  // reload while the operand is high, then count passes down
  always_comb begin
    cnt_nxt = cnt_r;
    if (sp.spv_raw) begin
      cnt_nxt = SPV_HOLD_LOAD;
    end else if (sp.pass_stb && cnt_r != SPV_CNT_RST) begin
      cnt_nxt = cnt_r - SPV_CNT_W'(1);
    end
    block_nxt = sp.spv_raw || (cnt_nxt != SPV_CNT_RST);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= SPV_CNT_RST;
      block_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      block_r <= block_nxt;
    end
  end

  assign sp.spv_block = block_r;

  ////////////////////////////////////////////////////////////////////
  spv_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sp.spv_raw |=> sp.spv_block && cnt_r == SPV_HOLD_LOAD)
    else $error("supervision did not block");
  spv_release_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !sp.spv_raw && sp.pass_stb && cnt_r == SPV_CNT_W'(1) |=> !sp.spv_block)
    else $error("supervision hold did not release");
  spv_hold_c: cover property (@(posedge core_clk) disable iff (!rstn)
    $fell(sp.spv_raw) ##1 sp.spv_block);
endmodule

// ---- verification/field_source.sv ----
// behavioural model of the transformers and breaker contact around the detector
module field_source (
  // clock
  input wire logic core_clk,
  // per-phase scene: 0 armed, 1 flashover, 2 closed, 3 dead, 4 live with current
  input wire logic [2:0][2:0] scene,
  // measurements
  output logic [2:0][15:0] side1_voltage,
  output logic [2:0][15:0] side2_voltage,
  output logic [2:0][15:0] voltage_difference,
  output logic [2:0][15:0] phase_current,
  output logic [2:0] breaker_closed_aux_contact
);
  timeunit 1ns;
  timeprecision 1ps;
  // nominal level; the far side holds values until the scene moves
  localparam logic [15:0] LIVE = 16'h0200;
  localparam logic [15:0] AMPS = 16'h0100;
  // side one carries both voltage and current; the contact is always supplied
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 3; i++) begin
      side1_voltage[i] <= (scene[i] inside {3'h0, 3'h2, 3'h4}) ? LIVE : 16'h0000;
      side2_voltage[i] <= (scene[i] inside {3'h2, 3'h4}) ? LIVE : 16'h0000;
      voltage_difference[i] <= (scene[i] == 3'h0) ? LIVE : 16'h0000;
      phase_current[i] <= (scene[i] inside {3'h1, 3'h2, 3'h4}) ? AMPS : 16'h0000;
      breaker_closed_aux_contact[i] <= (scene[i] == 3'h2);
    end
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the breaker flashover detector
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flashover_pkg::*;
  localparam logic [2:0] ARM = 3'h0, FL = 3'h1, CL = 3'h2, DEAD = 3'h3, LIVEI = 3'h4;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic pass_stb = 1'b0;
  logic ssel = 1'b0;
  logic contact_use = 1'b1;
  logic delta = 1'b0;
  logic [2:0] trip = 3'h0;
  logic [2:0][2:0] scene = {DEAD, DEAD, DEAD};
  logic [2:0][15:0] v1, v2, vd, ia;
  logic [2:0] aux, pk, op;
  logic pk_any, op_any;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  field_source src_u (.core_clk(core_clk), .scene(scene), .side1_voltage(v1),
    .side2_voltage(v2), .voltage_difference(vd), .phase_current(ia),
    .breaker_closed_aux_contact(aux));
  // voltage pickup at 87.5 percent of nominal, difference pickup below resistor level
  breaker_flashover_detector dut_u (.core_clk(core_clk), .rstn(rstn), .pass_stb(pass_stb),
    .second_side_source_select(ssel), .contact_in_use(contact_use), .delta_connected(delta),
    .phase_voltage_pickup(16'h01C0), .voltage_difference_pickup(16'h0080),
    .current_pickup(16'h0040), .operate_delay(16'h0002), .side1_voltage(v1),
    .side2_voltage(v2), .voltage_difference(vd), .phase_current(ia),
    .breaker_closed_aux_contact(aux), .supervision_operand(trip),
    .phase_pickup(pk), .phase_operate(op), .pickup_any(pk_any), .operate_any(op_any));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one protection pass; waits out the contact synchroniser before the strobe
  task automatic pass(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
    @(posedge core_clk);
    scene <= {c, b, a};
    repeat (4) @(posedge core_clk);
    pass_stb <= 1'b1;
    @(posedge core_clk);
    pass_stb <= 1'b0;
    @(negedge core_clk);
  endtask
  // fresh start between scenarios, exercising a mid-run reset
  task automatic restart(input logic six);
    @(posedge core_clk);
    rstn <= 1'b0;
    ssel <= six;
    repeat (2) @(posedge core_clk);
    `CHECK({pk, op, pk_any, op_any}, 8'h00)
    rstn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic three_vt_operate();
    restart(1'b0);
    pass(ARM, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    `CHECK({pk, pk_any}, 4'h3)
    pass(FL, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    `CHECK(op, 3'h0)
    pass(FL, DEAD, DEAD);
    `CHECK({op, op_any}, 4'h3)
    pass(DEAD, DEAD, DEAD);
    `CHECK({pk, op}, 6'h00)
  endtask
  task automatic dead_and_delta();
    restart(1'b0);
    pass(DEAD, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    `CHECK(pk, 3'h0)
    @(posedge core_clk);
    delta <= 1'b1;
    pass(ARM, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    `CHECK({pk, op}, 6'h00)
    @(posedge core_clk);
    delta <= 1'b0;
  endtask
  task automatic restart_timer();
    restart(1'b0);
    pass(ARM, ARM, DEAD);
    pass(FL, FL, DEAD);
    pass(LIVEI, LIVEI, DEAD);
    `CHECK(pk, 3'h0)
    pass(FL, FL, DEAD);
    `CHECK(pk, 3'h3)
    pass(FL, FL, DEAD);
    pass(FL, FL, DEAD);
    `CHECK(op, 3'h0)
    pass(CL, CL, DEAD);
    `CHECK(pk, 3'h0)
  endtask
  task automatic six_vt();
    restart(1'b1);
    contact_use <= 1'b0;
    pass(ARM, ARM, DEAD);
    pass(FL, FL, DEAD);
    `CHECK(pk, 3'h3)
    @(posedge core_clk);
    contact_use <= 1'b1;
  endtask
  task automatic supervised();
    restart(1'b0);
    pass(ARM, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    @(posedge core_clk);
    trip <= 3'h1;
    pass(FL, DEAD, DEAD);
    `CHECK(pk, 3'h0)
    @(posedge core_clk);
    trip <= 3'h0;
    // still blocked through the last held pass, so arming only resumes after it
    repeat (SPV_HOLD_PASSES - 1) pass(ARM, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    `CHECK(pk, 3'h0)
    pass(ARM, DEAD, DEAD);
    pass(FL, DEAD, DEAD);
    `CHECK(pk, 3'h1)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a hang is cut short well past the expected few hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    three_vt_operate();
    dead_and_delta();
    restart_timer();
    six_vt();
    supervised();
    conclude();
  end
endmodule
